// ===== rtl/acsp_pkg.sv
// acsp_pkg: constants and types for the adc serial configuration port
package acsp_pkg;
    // register map
    localparam logic [9:0] ADDR_MODE    = 10'h000;
    localparam logic [9:0] ADDR_RAND    = 10'h007;
    localparam logic [9:0] ADDR_CALDLY  = 10'h01E;
    localparam logic [9:0] ADDR_CALSTAT = 10'h0C0;
    localparam logic [9:0] ADDR_LAST    = 10'h15D;
    localparam logic [7:0] MODE_RST     = 8'h24;
    localparam logic [7:0] RAND_RST     = 8'h62;
    localparam logic [7:0] CALDLY_RST   = 8'h80;
    // mode register fields, each control mirrored across the byte
    localparam int MB_SHDN_HI = 7;
    localparam int MB_LSB_HI  = 6;
    localparam int MB_SRST_HI = 5;
    localparam int MB_STBY_HI = 4;
    localparam int MB_STBY_LO = 3;
    localparam int MB_SRST_LO = 2;
    localparam int MB_LSB_LO  = 1;
    localparam int MB_SHDN_LO = 0;
    localparam int CALSTAT_BIT = 7;
    // serial framing
    localparam logic [3:0] HDR_LAST_BIT  = 4'hF;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [1:0] LEN_STREAM    = 2'h3;
    // timing in sample-clock cycles: 2^20, 2^27, 2^30
    localparam logic [30:0] POR_INIT_CYC = 31'h0010_0000;
    localparam logic [30:0] CAL_CYC      = 31'h0800_0000;
    localparam logic [30:0] BG_CYC       = 31'h4000_0000;

    typedef struct packed {
        logic       rw;
        logic [1:0] len;
        logic [2:0] chip;
        logic [9:0] start_reg;
    } acsp_hdr_s;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } acsp_spi_s;

    typedef struct packed {
        acsp_spi_s spi;
        logic      rst_n;
        logic      strap_hi;
        logic      strap_lo;
        logic      follower;
        logic      sync_in;
    } acsp_in_s;

    localparam acsp_in_s IN_RST = '{spi: '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0}, rst_n: 1'b1,
                                    strap_hi: 1'b0, strap_lo: 1'b0, follower: 1'b0, sync_in: 1'b0};

    typedef enum logic [1:0] {SP_IDLE, SP_HDR, SP_DATA, SP_SKIP} acsp_sp_e;
    typedef enum logic [1:0] {CAL_HOLD, CAL_RUN, CAL_DONE} acsp_cal_e;
endpackage

// ===== rtl/acsp_top.sv
// acsp_top: serial configuration port, reset and calibration control of the adc
//
// Overview of operation
// R01: power-up calibration, then periodic background calibration
// R02: calibration done shown on pin and register
// R03: host recalibrates by reset after changes
// R04: no output, clocks stopped during reset
// R05: reset pin release loads defaults, recalibrates
// R06: soft reset holds calibration; release recalibrates
// R07: shutdown kills reference/clock; standby keeps them
// R08: host soft-resets when leaving power saving
// R09: role pin low makes strobe an output
// R10: host discards data until calibration done
// R11: transaction starts after select falls; idle released
// R12: host holds select low for whole transaction
// R13: host keeps serial clock below maximum
// R14: sixteen-bit header; read turns pin around
// R15: length code selects 1-3 bytes or streaming
// R16: chip address matches zero and straps
// R17: ten-bit start address, eight-bit data bytes
// R18: msb first, lsb first when bit set
// R19: write sampled on rise, read driven on fall
// R20: address increments per byte, never wraps
// R21: registers load defaults after power-on delay
// R22: last registers read-only; host avoids unlisted
// R23: mode controls mirrored, soft reset active low
// R24: ignore and stay undriven on address mismatch
// R25: release data pin when select rises
`timescale 1ns/1ps
`default_nettype none
module acsp_top
    import acsp_pkg::*;
#(
    parameter logic [30:0] POR_INIT_CYCLES = acsp_pkg::POR_INIT_CYC,
    parameter logic [30:0] CAL_CYCLES      = acsp_pkg::CAL_CYC,
    parameter logic [30:0] BG_CYCLES       = acsp_pkg::BG_CYC
) (
    // clock and power-on reset
    input  wire logic               clock,
    input  wire logic               rst,
    // serial port pins
    input  wire acsp_pkg::acsp_spi_s spi_in,
    output logic                    sdio_out,
    output logic                    sdio_oe,
    // reset pin and chip address straps
    input  wire logic               hw_reset_n,
    input  wire logic               chip_addr_strap_high,
    input  wire logic               chip_addr_strap_low,
    // alignment strobe
    input  wire logic               role_follower,
    input  wire logic               sync_in,
    output logic                    sync_out,
    output logic                    sync_oe,
    // converter control and status
    output logic                    cal_done,
    output logic                    bg_cal,
    output logic                    conv_en,
    output logic                    clk_run,
    output logic                    ref_on
);
    import acsp_pkg::*;

    acsp_in_s  raw;
    acsp_in_s  meta_r;
    acsp_in_s  sy_r;
    logic      sclk_d_r;
    logic      rstn_d_r;
    logic      sync_d_r;

    assign raw = '{spi: spi_in, rst_n: hw_reset_n, strap_hi: chip_addr_strap_high,
                   strap_lo: chip_addr_strap_low, follower: role_follower, sync_in: sync_in};

    // every pin passes two flops; edges compare the second stage with a third, delayed copy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_r   <= IN_RST;
            sy_r     <= IN_RST;
            sclk_d_r <= 1'b0;
            rstn_d_r <= 1'b1;
            sync_d_r <= 1'b0;
        end else begin
            meta_r   <= raw;
            sy_r     <= meta_r;
            sclk_d_r <= sy_r.spi.sclk;
            rstn_d_r <= sy_r.rst_n;
            sync_d_r <= sy_r.sync_in;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_s;
    assign sclk_rise = sy_r.spi.sclk & ~sclk_d_r;
    assign sclk_fall = ~sy_r.spi.sclk & sclk_d_r;
    assign cs_s      = sy_r.spi.cs_n;

    // ---------------- register file and serial engine ----------------
    acsp_sp_e   sp_st_r, sp_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [3:0]  bit_r, bit_nxt;
    logic [9:0]  addr_r, addr_nxt;
    logic [1:0]  len_r, len_nxt;
    logic [1:0]  nbyte_r, nbyte_nxt;
    logic        rd_r, rd_nxt;
    logic        sdo_r, sdo_nxt;
    logic        oe_r, oe_nxt;
    logic [7:0]  mode_r, mode_nxt;
    logic [7:0]  rand_r, rand_nxt;
    logic [7:0]  caldly_r, caldly_nxt;
    logic        init_done_r;
    logic        cal_done_r;
    logic        byte_done;
    logic        lsb_first;
    acsp_hdr_s   hdr;
    logic [15:0] hsh;
    logic [7:0]  wbyte;

    // R23 mirrored controls: either copy asserts the function
    assign lsb_first = mode_r[MB_LSB_HI] | mode_r[MB_LSB_LO];

    // R22 unmapped addresses read zero; status register ignores writes
    function automatic logic [7:0] rd_reg(input logic [9:0] a, input logic [7:0] m,
                                          input logic [7:0] r, input logic [7:0] d,
                                          input logic c);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_MODE:    v = m;
            ADDR_RAND:    v = r;
            ADDR_CALDLY:  v = d;
            // R02 status bit mirrors the pin
            ADDR_CALSTAT: v[CALSTAT_BIT] = c;
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        sp_nxt     = sp_st_r;
        sh_nxt     = sh_r;
        bit_nxt    = bit_r;
        addr_nxt   = addr_r;
        len_nxt    = len_r;
        nbyte_nxt  = nbyte_r;
        rd_nxt     = rd_r;
        sdo_nxt    = sdo_r;
        oe_nxt     = oe_r;
        mode_nxt   = mode_r;
        rand_nxt   = rand_r;
        caldly_nxt = caldly_r;
        byte_done  = 1'b0;
        // R18 header and data shift direction follow the bit-order control
        hsh   = lsb_first ? {sy_r.spi.sdi, sh_r[15:1]} : {sh_r[14:0], sy_r.spi.sdi};
        hdr   = acsp_hdr_s'(hsh);
        wbyte = lsb_first ? {sy_r.spi.sdi, sh_r[7:1]} : {sh_r[6:0], sy_r.spi.sdi};
        // R11 R25 select high: port idle and pin released
        if (cs_s || !init_done_r) begin
            sp_nxt = SP_IDLE;
            oe_nxt = 1'b0;
        end else begin
            case (sp_st_r)
                // R11 frame begins with the first rise after select falls
                SP_IDLE: begin
                    sp_nxt  = SP_HDR;
                    bit_nxt = 4'h0;
                end
                SP_HDR: if (sclk_rise) begin
                    sh_nxt  = hsh;
                    bit_nxt = bit_r + 4'h1;
                    // R14 sixteen header bits complete
                    if (bit_r == HDR_LAST_BIT) begin
                        bit_nxt = 4'h0;
                        // R16 R24 foreign chip address: ignore, stay undriven
                        if (hdr.chip != {1'b0, sy_r.strap_hi, sy_r.strap_lo}) begin
                            sp_nxt = SP_SKIP;
                            oe_nxt = 1'b0;
                        end else begin
                            // R17 start address from header
                            sp_nxt    = SP_DATA;
                            addr_nxt  = hdr.start_reg;
                            len_nxt   = hdr.len;
                            nbyte_nxt = 2'h0;
                            rd_nxt    = hdr.rw;
                            // R14 read turns the pin around after the header
                            oe_nxt    = hdr.rw;
                            sh_nxt    = {8'h00, rd_reg(hdr.start_reg, mode_r, rand_r, caldly_r, cal_done_r)};
                        end
                    end
                end
                SP_DATA: begin
                    // R19 read data changes on the falling edge
                    if (sclk_fall && rd_r) begin
                        sdo_nxt = lsb_first ? sh_r[0] : sh_r[7];
                        sh_nxt  = lsb_first ? {9'h000, sh_r[7:1]} : {8'h00, sh_r[6:0], 1'b0};
                    end
                    // R19 write data sampled on the rising edge
                    if (sclk_rise) begin
                        if (!rd_r) begin
                            sh_nxt = {8'h00, wbyte};
                        end
                        bit_nxt = bit_r + 4'h1;
                        if (bit_r == BYTE_LAST_BIT) begin
                            byte_done = 1'b1;
                            bit_nxt   = 4'h0;
                            nbyte_nxt = nbyte_r + 2'h1;
                            if (!rd_r) begin
                                case (addr_r)
                                    ADDR_MODE:   mode_nxt   = wbyte;
                                    ADDR_RAND:   rand_nxt   = wbyte;
                                    ADDR_CALDLY: caldly_nxt = wbyte;
                                    default:     mode_nxt   = mode_r;
                                endcase
                            end
                            // R20 step per byte, hold at the last address
                            if (addr_r != ADDR_LAST) begin
                                addr_nxt = addr_r + 10'h001;
                            end
                            if (rd_r) begin
                                sh_nxt = {8'h00, rd_reg(addr_nxt, mode_r, rand_r, caldly_r, cal_done_r)};
                            end
                            // R15 fixed length ends after len+1 bytes; code 3 streams
                            if (len_r != LEN_STREAM && nbyte_r == len_r) begin
                                sp_nxt = SP_SKIP;
                                oe_nxt = 1'b0;
                            end
                        end
                    end
                end
                SP_SKIP: oe_nxt = 1'b0;
                default: sp_nxt = SP_IDLE;
            endcase
        end
        // R05 R21 defaults held until power-on delay ends and while reset pin low
        if (!sy_r.rst_n || !init_done_r) begin
            mode_nxt   = MODE_RST;
            rand_nxt   = RAND_RST;
            caldly_nxt = CALDLY_RST;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sp_st_r  <= SP_IDLE;
            sh_r     <= 16'h0000;
            bit_r    <= 4'h0;
            addr_r   <= 10'h000;
            len_r    <= 2'h0;
            nbyte_r  <= 2'h0;
            rd_r     <= 1'b0;
            sdo_r    <= 1'b0;
            oe_r     <= 1'b0;
            mode_r   <= MODE_RST;
            rand_r   <= RAND_RST;
            caldly_r <= CALDLY_RST;
        end else begin
            sp_st_r  <= sp_nxt;
            sh_r     <= sh_nxt;
            bit_r    <= bit_nxt;
            addr_r   <= addr_nxt;
            len_r    <= len_nxt;
            nbyte_r  <= nbyte_nxt;
            rd_r     <= rd_nxt;
            sdo_r    <= sdo_nxt;
            oe_r     <= oe_nxt;
            mode_r   <= mode_nxt;
            rand_r   <= rand_nxt;
            caldly_r <= caldly_nxt;
        end
    end

    // ---------------- reset, calibration and power control ----------------
    acsp_cal_e   cal_st_r, cal_nxt;
    logic [30:0] cnt_r, cnt_nxt;
    logic        init_nxt;
    logic        soft_prev_r;
    logic        bg_r, bg_nxt;
    logic        syo_r, syo_nxt;
    logic        conv_r, conv_nxt;
    logic        clk_r, clk_nxt;
    logic        ref_r, ref_nxt;
    logic        soft_act;
    logic        shdn;
    logic        stby;
    logic        hold_c;
    logic        start_c;
    logic        cal_fin;

    // R23 soft reset is active low in either mirrored position
    assign soft_act = ~(mode_r[MB_SRST_HI] & mode_r[MB_SRST_LO]);
    assign shdn     = mode_r[MB_SHDN_HI] | mode_r[MB_SHDN_LO];
    assign stby     = mode_r[MB_STBY_HI] | mode_r[MB_STBY_LO];
    assign hold_c   = ~sy_r.rst_n | soft_act;
    // R05 R06 R09 restart on reset-pin rise, soft release or leader strobe
    assign start_c  = (sy_r.rst_n & ~rstn_d_r) | (soft_prev_r & ~soft_act) |
                      (sy_r.follower & sy_r.sync_in & ~sync_d_r);
    assign cal_fin  = (cal_st_r == CAL_RUN) && (cnt_r == CAL_CYCLES - 31'h1);

    always_comb begin
        cal_nxt  = cal_st_r;
        cnt_nxt  = cnt_r + 31'h1;
        init_nxt = init_done_r;
        bg_nxt   = 1'b0;
        syo_nxt  = 1'b0;
        // R21 power-on delay expiry releases the held defaults and starts the first calibration
        if (!init_done_r) begin
            if (cnt_r == POR_INIT_CYCLES - 31'h1) begin
                init_nxt = 1'b1;
                cal_nxt  = CAL_RUN;
                cnt_nxt  = 31'h0;
                syo_nxt  = 1'b1;
            end
        // R04 R06 calibration held at defaults during any reset
        end else if (hold_c) begin
            cal_nxt = CAL_HOLD;
            cnt_nxt = 31'h0;
        end else if (start_c) begin
            cal_nxt = CAL_RUN;
            cnt_nxt = 31'h0;
            syo_nxt = 1'b1;
        end else begin
            case (cal_st_r)
                // R01 full calibration length
                CAL_RUN: if (cal_fin) begin
                    cal_nxt = CAL_DONE;
                    cnt_nxt = 31'h0;
                end
                // R01 background refresh, invisible to the status
                CAL_DONE: if (cnt_r == BG_CYCLES - 31'h1) begin
                    bg_nxt  = 1'b1;
                    cnt_nxt = 31'h0;
                end
                CAL_HOLD: cnt_nxt = 31'h0;
                default:  cal_nxt = CAL_HOLD;
            endcase
        end
        // R04 no conversion output and clocks stopped while in reset
        conv_nxt = init_nxt & ~hold_c & ~shdn & ~stby;
        // R07 shutdown drops reference and clock; standby keeps both
        clk_nxt  = ~hold_c & ~shdn;
        ref_nxt  = ~shdn;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cal_st_r    <= CAL_HOLD;
            cnt_r       <= 31'h0;
            init_done_r <= 1'b0;
            soft_prev_r <= 1'b0;
            cal_done_r  <= 1'b0;
            bg_r        <= 1'b0;
            syo_r       <= 1'b0;
            sync_oe     <= 1'b0;
            conv_r      <= 1'b0;
            clk_r       <= 1'b0;
            ref_r       <= 1'b0;
        end else begin
            cal_st_r    <= cal_nxt;
            cnt_r       <= cnt_nxt;
            init_done_r <= init_nxt;
            soft_prev_r <= soft_act;
            // R02 pin and status bit both follow completion
            cal_done_r  <= (cal_nxt == CAL_DONE);
            bg_r        <= bg_nxt;
            // R09 leader drives the strobe, follower listens
            syo_r       <= syo_nxt & ~sy_r.follower;
            sync_oe     <= ~sy_r.follower;
            conv_r      <= conv_nxt;
            clk_r       <= clk_nxt;
            ref_r       <= ref_nxt;
        end
    end

    assign sdio_out = sdo_r;
    assign sdio_oe  = oe_r;
    assign sync_out = syo_r;
    assign cal_done = cal_done_r;
    assign bg_cal   = bg_r;
    assign conv_en  = conv_r;
    assign clk_run  = clk_r;
    assign ref_on   = ref_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    idle_release_a: assert property (cs_s |=> !sdio_oe) // R11
        else $error("data pin driven while select high");
    skip_quiet_a: assert property (sp_st_r == SP_SKIP |-> !sdio_oe) // R24
        else $error("data pin driven in ignored frame");
    addr_step_a: assert property (byte_done && addr_r != ADDR_LAST |=> addr_r == $past(addr_r) + 10'h001) // R20
        else $error("register address did not step by one");
    addr_hold_a: assert property (byte_done && addr_r == ADDR_LAST |=> addr_r == ADDR_LAST) // R20
        else $error("register address moved past the last one");
    cal_len_a: assert property (cal_fin && !hold_c && !start_c |=> cal_done && cnt_r == 31'h0) // R01
        else $error("calibration did not complete at its length");
    cal_pin_a: assert property (cal_done |-> cal_st_r == CAL_DONE && !$past(hold_c)) // R02
        else $error("calibration done shown while not complete");
    reset_quiet_a: assert property (hold_c |=> !conv_en && !clk_run && !cal_done) // R04
        else $error("output or clocks active during reset");
    hw_defaults_a: assert property (!sy_r.rst_n |=> mode_r == MODE_RST && rand_r == RAND_RST) // R05
        else $error("defaults not held by reset pin");
    soft_release_a: assert property (init_done_r && sy_r.rst_n && soft_prev_r && !soft_act
                                     |=> cal_st_r == CAL_RUN && cnt_r == 31'h0) // R06
        else $error("soft reset release did not restart calibration");
    shutdown_a: assert property (shdn |=> !ref_on && !clk_run && !conv_en) // R07
        else $error("reference or clock alive in shutdown");
    leader_a: assert property (!sy_r.follower |=> sync_oe) // R09
        else $error("leader strobe not driven");
endmodule // acsp_top
`default_nettype wire

// ===== dv/acsp_host.sv
// acsp_host: serial bus master model driving the configuration port
`timescale 1ns/1ps
`default_nettype none
module acsp_host
    import acsp_pkg::*;
(
    // clock and device pin side
    input  wire logic           clock,
    input  wire logic           sdio_out,
    input  wire logic           sdio_oe,
    // pins towards the device
    output acsp_pkg::acsp_spi_s spi
);
    logic cs_n_r = 1'b1;
    logic sclk_r = 1'b0;
    logic drv_r  = 1'b0;
    logic bit_r  = 1'b0;
    // no pull on the wire: released, it shows the inverse of the last bit
    assign spi = '{cs_n: cs_n_r, sclk: sclk_r, sdi: sdio_oe ? sdio_out : (drv_r ? bit_r : ~bit_r)};

    task automatic tick(input int n, inout logic seen);
        repeat (n) begin
            @(posedge clock);
            seen = seen | sdio_oe;
        end
    endtask

    // 400 ns sclk, data set on fall, taken at rise
    task automatic xfer(input logic [15:0] hdr, input int nby, input logic [23:0] wd,
                        input logic lsb, output logic [23:0] rd, output logic seen);
        int p;
        rd = '0;
        seen = 1'b0;
        tick(1, seen);
        // select low over the whole frame
        cs_n_r <= 1'b0;
        tick(4, seen);
        for (int i = 0; i < 16 + 8 * nby; i++) begin
            // header then bytes, reversed in lsb mode
            p = (i < 16) ? (lsb ? i : 15 - i) : (16 - 8 * ((i - 16) / 8) + (lsb ? i % 8 : 7 - i % 8));
            sclk_r <= 1'b0;
            drv_r  <= !(hdr[15] && i >= 16);
            bit_r  <= (i < 16) ? hdr[p] : wd[p];
            tick(5, seen);
            if (i >= 16)
                rd[p] = spi.sdi;
            sclk_r <= 1'b1;
            tick(3, seen);
        end
        sclk_r <= 1'b0;
        tick(4, seen);
        cs_n_r <= 1'b1;
        drv_r  <= 1'b0;
        tick(4, seen);
    endtask
endmodule // acsp_host
`default_nettype wire

// ===== dv/tb_acsp_top.sv
// tb_acsp_top: self-checking bench for the adc configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_acsp_top;
    import acsp_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        hw_reset_n = 1'b1;
    logic        strap_hi = 1'b0;
    logic        strap_lo = 1'b0;
    logic        follower = 1'b0;
    logic        sync_in = 1'b0;
    acsp_spi_s   spi;
    logic        sdio_out, sdio_oe, sync_out, sync_oe, cal_done, bg_cal, conv_en, clk_run, ref_on;
    int          errors = 0;
    int          n_checks = 0;
    int          n_sync = 0;
    int          k, n0;
    logic [23:0] rd;
    logic        seen;
    logic [2:0]  chip = 3'b000;

    always #25 clock = ~clock;
    always @(posedge clock)
        if (sync_out)
            n_sync++;

    acsp_top #(.POR_INIT_CYCLES(31'h40), .CAL_CYCLES(31'hC8), .BG_CYCLES(31'h3E8)) i_dut (
        .clock(clock), .rst(rst), .spi_in(spi), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .hw_reset_n(hw_reset_n), .chip_addr_strap_high(strap_hi), .chip_addr_strap_low(strap_lo),
        .role_follower(follower), .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
        .cal_done(cal_done), .bg_cal(bg_cal), .conv_en(conv_en), .clk_run(clk_run), .ref_on(ref_on));
    acsp_host i_host (.clock(clock), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .spi(spi));

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // bounded wait on cal_done (0), bg_cal (1) or sync_out (2); k holds the cycles
    task automatic await(input int sel, input logic v, input int lim);
        logic s;
        k = 0;
        s = ~v;
        while (s !== v) begin
            @(posedge clock);
            k++;
            s = (sel == 0) ? cal_done : (sel == 1) ? bg_cal : sync_out;
            if (k > lim) begin
                errors++;
                $display("MISMATCH t=%0t wait ran out", $time);
                summarize();
            end
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic lsb);
        i_host.xfer({1'b0, 2'b00, chip, a}, 1, {d, 16'h0000}, lsb, rd, seen);
    endtask

    task automatic rdc(input logic [9:0] a, input logic [1:0] len, input int n, input logic [23:0] exp,
                       input logic lsb);
        i_host.xfer({1'b1, len, chip, a}, n, 24'h000000, lsb, rd, seen);
        check(rd, exp);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        check(24'({sdio_oe, cal_done, conv_en, clk_run, ref_on}), 24'h0);
        await(0, 1'b1, 400);
        check(24'(k > 250), 24'h1);
        check(24'({conv_en, clk_run, ref_on, sync_oe}), 24'hF);
        await(1, 1'b1, 1100);
        await(1, 1'b0, 5);
        await(1, 1'b1, 1100);
        check(24'(k > 990 && k < 1010), 24'h1);
        $display("test calibration timing done");
        rdc(ADDR_MODE, 2'b00, 1, {MODE_RST, 16'h0000}, 1'b0);
        rdc(ADDR_CALDLY, 2'b00, 1, {CALDLY_RST, 16'h0000}, 1'b0);
        rdc(ADDR_CALSTAT, 2'b00, 1, 24'h800000, 1'b0);
        rdc(10'h005, 2'b10, 3, {16'h0000, RAND_RST}, 1'b0);
        i_host.xfer({1'b0, 2'b01, chip, 10'h006}, 2, 24'h113300, 1'b0, rd, seen);
        rdc(ADDR_RAND, 2'b00, 1, 24'h330000, 1'b0);
        wr(ADDR_CALSTAT, 8'h00, 1'b0);
        rdc(ADDR_CALSTAT, 2'b00, 1, 24'h800000, 1'b0);
        rdc(10'h15C, 2'b11, 3, 24'h000000, 1'b0);
        check(24'(sdio_oe), 24'h0);
        $display("test register access done");
        strap_hi <= 1'b1;
        strap_lo <= 1'b1;
        // foreign addresses: all zero, one strap wrong, top bit set
        for (int j = 0; j < 3; j++) begin
            chip = (j == 0) ? 3'b000 : (j == 1) ? 3'b010 : 3'b111;
            i_host.xfer({1'b1, 2'b00, chip, ADDR_MODE}, 1, 24'h0, 1'b0, rd, seen);
            check(24'(seen), 24'h0);
        end
        chip = 3'b011;
        rdc(ADDR_MODE, 2'b00, 1, 24'h240000, 1'b0);
        $display("test chip address done");
        wr(ADDR_CALDLY, 8'h5A, 1'b0);
        wr(ADDR_MODE, 8'h20, 1'b0);
        check(24'({cal_done, conv_en, clk_run, ref_on}), 24'h1);
        rdc(ADDR_CALDLY, 2'b00, 1, 24'h5A0000, 1'b0);
        n0 = n_sync;
        wr(ADDR_MODE, MODE_RST, 1'b0);
        await(0, 1'b1, 260);
        check(24'(k > 170), 24'h1);
        check(24'(n_sync - n0), 24'h1);
        $display("test soft reset done");
        wr(ADDR_MODE, 8'h66, 1'b0);
        rdc(ADDR_RAND, 2'b00, 1, 24'h330000, 1'b1);
        wr(ADDR_MODE, MODE_RST, 1'b1);
        rdc(ADDR_MODE, 2'b00, 1, 24'h240000, 1'b0);
        $display("test bit order done");
        wr(ADDR_MODE, 8'hA5, 1'b0);
        check(24'({ref_on, clk_run, conv_en}), 24'h0);
        wr(ADDR_MODE, 8'h3C, 1'b0);
        check(24'({ref_on, clk_run, conv_en}), 24'h6);
        // leave power saving together with a soft reset
        wr(ADDR_MODE, 8'h00, 1'b0);
        wr(ADDR_MODE, MODE_RST, 1'b0);
        await(0, 1'b1, 260);
        $display("test power saving done");
        n0 = n_sync;
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge clock);
        check(24'({cal_done, conv_en, clk_run}), 24'h0);
        hw_reset_n <= 1'b1;
        await(0, 1'b1, 260);
        check(24'(n_sync - n0), 24'h1);
        rdc(ADDR_CALDLY, 2'b00, 1, {CALDLY_RST, 16'h0000}, 1'b0);
        $display("test hardware reset done");
        follower <= 1'b1;
        repeat (6) @(posedge clock);
        check(24'(sync_oe), 24'h0);
        n0 = n_sync;
        sync_in <= 1'b1;
        await(0, 1'b0, 10);
        await(0, 1'b1, 260);
        check(24'(n_sync - n0), 24'h0);
        $display("test follower done");
        summarize();
    end
endmodule // tb_acsp_top
`default_nettype wire
